// ---- core/dpsu_core.sv ----
// Security set password and unlock command engine with an APB register port
//
// Summary of operation
// - Good completion clears busy, fault, data request, error; sets ready.
// - Set password aborts when unsupported, locked or frozen.
// - Listed aborts set only the command rejected bit, error bit 2.
// - Error completion clears busy and data request; error summary follows error bits.
// - Each accepted set password or unlock command takes exactly one 256-word parameter sector; freeze takes none.
// - Word 0 bit 0 picks User or Master, bit 8 picks High or Maximum.
// - Words 1 to 16 hold password; word 17 revision used for Master only.
// - Revision codes up to FFFDh valid, FFFEh default, FFFFh reserved.
// - User at High stores password, arms lock; User or Master unlocks.
// - User at Maximum stores password, arms lock; Master never unlocks.
// - Master set replaces Master password and revision; lock and level kept.
// - Master unlock compares at High, is rejected at Maximum.
// - User unlock compares against stored User password.
// - Mismatch while locked aborts and decrements tries counter starting at five.
// - At zero tries every unlock aborts until a reset restores it.
// - Unlock while unlocked leaves tries counter unchanged.
// - Unlock aborts when unsupported or frozen.
// - Unlock opcode F2h, command then one data-out sector.
// - Unperformable requests may also set command rejected bit.
// - Drive select bit reflects the selected device on every completion.
// - Frozen mode holds until power loss or hardware reset.
// - Set password opcode F1h with data-out sector.
`timescale 1ns/1ns
module dpsu_core
    import dpsu_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Hardware reset pulse from the interface logic
    input wire logic hw_reset_i,
    // APB slave
    input wire dpsu_apb_s apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Security state
    output logic locked_o,
    output logic frozen_o
);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic setup_ph;
    logic wr_acc;
    logic addr_hit;
    logic cmd_wr;
    logic data_wr;
    logic [WORD_W-1:0] wword;

    assign setup_ph = apb_i.psel && !apb_i.penable;
    assign wr_acc = apb_i.psel && apb_i.penable && apb_i.pwrite;
    assign wword = apb_i.pwdata[WORD_W-1:0];

    always_comb begin
        if (apb_i.paddr == ADDR_ERROR) begin
            addr_hit = 1'b1;
        end else if (apb_i.paddr == ADDR_DEVHEAD) begin
            addr_hit = 1'b1;
        end else if (apb_i.paddr == ADDR_CMD) begin
            addr_hit = 1'b1;
        end else if (apb_i.paddr == ADDR_STATUS) begin
            addr_hit = 1'b1;
        end else if (apb_i.paddr == ADDR_DATA) begin
            addr_hit = 1'b1;
        end else if (apb_i.paddr == ADDR_SECSTATE) begin
            addr_hit = 1'b1;
        end else if (apb_i.paddr == ADDR_CTRL) begin
            addr_hit = 1'b1;
        end else begin
            addr_hit = 1'b0;
        end
    end

    // Zero wait states: read data is captured in the setup phase
    assign pready_o = 1'b1;
    assign pslverr_o = apb_i.psel && apb_i.penable && !addr_hit;

    // ----------------------------------------
    // State and registers
    // ----------------------------------------
    dpsu_state_e state_q;
    logic [7:0] opc_q;
    logic [7:0] error_q;
    logic [7:0] dev_head_q;
    logic [31:0] ctrl_q;
    logic busy_q;
    logic ready_q;
    logic drq_q;
    logic [7:0] wcnt_q;
    logic id_master_q;
    logic lvl_new_q;
    logic mismatch;
    dpsu_sec_s sec_q;
    logic [7:0] status;

    assign cmd_wr = wr_acc && (apb_i.paddr == ADDR_CMD) && (state_q == S_IDLE);
    // Data words outside a requested sector are dropped
    assign data_wr = wr_acc && (apb_i.paddr == ADDR_DATA) && drq_q && (state_q == S_XFER);

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    logic is_set;
    logic is_unl;
    logic is_frz;
    logic supported;
    logic pre_abort;
    logic go_xfer;
    logic fin_abort;
    logic master_barred;

    assign is_set = (opc_q == OPC_SET_PWD);
    assign is_unl = (opc_q == OPC_UNLOCK);
    assign is_frz = (opc_q == OPC_FREEZE);
    assign supported = ctrl_q[CTRL_SUPPORT] && (is_set || is_unl || is_frz);

    always_comb begin
        pre_abort = !supported;
        if (is_set && (sec_q.locked || sec_q.frozen)) begin
            pre_abort = 1'b1;
        end
        if (is_unl && (sec_q.frozen || (sec_q.tries == '0))) begin
            pre_abort = 1'b1;
        end
        if (is_frz && sec_q.locked) begin
            pre_abort = 1'b1;
        end
    end

    assign go_xfer = (is_set || is_unl) && !pre_abort;

    assign master_barred = id_master_q && sec_q.level_max;
    assign fin_abort = is_unl && (master_barred || mismatch);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= S_IDLE;
        end else if (hw_reset_i) begin
            state_q <= S_IDLE;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (cmd_wr) begin
                        state_q <= S_DECODE;
                    end
                end
                S_DECODE: begin
                    state_q <= go_xfer ? S_XFER : S_IDLE;
                end
                S_XFER: begin
                    if (data_wr && (wcnt_q == WORD_LAST)) begin
                        state_q <= S_FINISH;
                    end
                end
                S_FINISH: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            opc_q <= '0;
        end else if (cmd_wr) begin
            opc_q <= apb_i.pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wcnt_q <= '0;
            id_master_q <= 1'b0;
            lvl_new_q <= 1'b0;
        end else if (state_q == S_DECODE) begin
            wcnt_q <= '0;
        end else if (data_wr) begin
            wcnt_q <= wcnt_q + 8'h01;
            if (wcnt_q == WORD_CTRL) begin
                id_master_q <= wword[CW_ID_BIT];
                lvl_new_q <= wword[CW_LVL_BIT];
            end
        end
    end

    // ----------------------------------------
    // Password bank
    // ----------------------------------------
    logic pwd_word;
    logic [3:0] pwd_idx;
    logic [7:0] pwd_off;

    // words 1 to 16 carry the password
    assign pwd_word = data_wr && (wcnt_q >= WORD_PWD_FIRST) && (wcnt_q <= WORD_PWD_LAST);
    assign pwd_off = wcnt_q - WORD_PWD_FIRST;
    assign pwd_idx = pwd_off[3:0];

    dpsu_pwd_bank #(
        .WORDS(PWD_WORDS),
        .W(WORD_W)
    ) u_bank (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .clr_i(state_q == S_DECODE),
        .we_i(pwd_word && is_set),
        .cmp_i(pwd_word && is_unl),
        .sel_master_i(id_master_q),
        .idx_i(pwd_idx),
        .word_i(wword),
        .mismatch_o(mismatch)
    );

    // ----------------------------------------
    // Task-file flags
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_q <= 1'b0;
            ready_q <= 1'b1;
            drq_q <= 1'b0;
            error_q <= '0;
        end else if (hw_reset_i) begin
            busy_q <= 1'b0;
            ready_q <= 1'b1;
            drq_q <= 1'b0;
            error_q <= '0;
        end else if (cmd_wr) begin
            busy_q <= 1'b1;
            ready_q <= 1'b0;
            error_q <= '0;
        end else if (state_q == S_DECODE) begin
            busy_q <= 1'b0;
            drq_q <= go_xfer;
            ready_q <= !go_xfer;
            error_q[ERR_COMMAND_REJECTED_FLAG] <= pre_abort;
        end else if (data_wr && (wcnt_q == WORD_LAST)) begin
            busy_q <= 1'b1;
            drq_q <= 1'b0;
        end else if (state_q == S_FINISH) begin
            busy_q <= 1'b0;
            ready_q <= 1'b1;
            error_q[ERR_COMMAND_REJECTED_FLAG] <= fin_abort;
        end
    end

    // ----------------------------------------
    // Security state
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sec_q.frozen <= 1'b0;
            sec_q.locked <= 1'b0;
            sec_q.armed <= 1'b0;
            sec_q.level_max <= 1'b0;
            sec_q.tries <= TRIES_INIT;
            sec_q.rev <= REV_DEFAULT;
        end else if (hw_reset_i) begin
            sec_q.frozen <= 1'b0;
            sec_q.locked <= sec_q.armed;
            sec_q.tries <= TRIES_INIT;
        end else begin
            if ((state_q == S_DECODE) && is_frz && !pre_abort) begin
                sec_q.frozen <= 1'b1;
            end
            if (data_wr && is_set && id_master_q && (wcnt_q == WORD_REV) && (wword != REV_RESERVED)) begin
                sec_q.rev <= wword;
            end
            if ((state_q == S_FINISH) && is_set && !id_master_q) begin
                sec_q.armed <= 1'b1;
                sec_q.level_max <= lvl_new_q;
            end
            if ((state_q == S_FINISH) && is_unl) begin
                if (!fin_abort) begin
                    sec_q.locked <= 1'b0;
                end else if (mismatch && !master_barred && sec_q.locked && (sec_q.tries != '0)) begin
                    sec_q.tries <= sec_q.tries - 3'h1;
                end
            end
        end
    end

    assign locked_o = sec_q.locked;
    assign frozen_o = sec_q.frozen;

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    // drive select held for completions
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dev_head_q <= '0;
        end else if (wr_acc && (apb_i.paddr == ADDR_DEVHEAD)) begin
            dev_head_q <= apb_i.pwdata[7:0];
        end
    end

    // Feature enable lets software model a drive without the security set
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_acc && (apb_i.paddr == ADDR_CTRL)) begin
            ctrl_q <= apb_i.pwdata & CTRL_RESET;
        end
    end

    always_comb begin
        status = '0;
        status[STAT_BUSY] = busy_q;
        status[STAT_READY] = ready_q;
        status[STAT_FAULT] = 1'b0;
        status[STAT_DRQ] = drq_q;
        status[STAT_ERR] = |error_q;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= '0;
        end else if (setup_ph && !apb_i.pwrite) begin
            if (apb_i.paddr == ADDR_ERROR) begin
                prdata_o <= {24'h000000, error_q};
            end else if (apb_i.paddr == ADDR_DEVHEAD) begin
                prdata_o <= {24'h000000, dev_head_q};
            end else if (apb_i.paddr == ADDR_STATUS) begin
                prdata_o <= {24'h000000, status};
            end else if (apb_i.paddr == ADDR_SECSTATE) begin
                prdata_o <= {9'h000, sec_q};
            end else if (apb_i.paddr == ADDR_CTRL) begin
                prdata_o <= ctrl_q;
            end else begin
                prdata_o <= '0;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    logic [8:0] words_seen_q;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            words_seen_q <= '0;
        end else if (state_q == S_DECODE) begin
            words_seen_q <= '0;
        end else if (data_wr) begin
            words_seen_q <= words_seen_q + 9'h001;
        end
    end

    sequence seq_set_issued;
        (state_q == S_DECODE) && is_set && !hw_reset_i;
    endsequence

    sequence seq_unl_finish;
        (state_q == S_FINISH) && is_unl && !hw_reset_i;
    endsequence

    a_done_ok_flags: assert property (
        (state_q == S_FINISH) && !fin_abort && !hw_reset_i
        |=> ready_q && !busy_q && !drq_q && !status[STAT_ERR] && !status[STAT_FAULT])
        else $error("clean completion flags wrong");

    a_set_refused: assert property (
        seq_set_issued ##0 (sec_q.locked || sec_q.frozen)
        |=> error_q[ERR_COMMAND_REJECTED_FLAG] && ready_q && (state_q == S_IDLE))
        else $error("set password not refused");

    a_error_only_command_rejected_flag: assert property (
        (error_q & ~(8'h01 << ERR_COMMAND_REJECTED_FLAG)) == 8'h00)
        else $error("unexpected error bit");

    a_err_summary: assert property (
        (status[STAT_ERR] == error_q[ERR_COMMAND_REJECTED_FLAG]) and (status[STAT_ERR] && ready_q |-> !drq_q && !busy_q))
        else $error("error summary mismatch");

    a_one_sector: assert property (
        $fell(drq_q) && !$past(hw_reset_i) |-> words_seen_q == 9'h100)
        else $error("sector length wrong");

    a_master_barred: assert property (
        seq_unl_finish ##0 master_barred |=> error_q[ERR_COMMAND_REJECTED_FLAG] ##0 $stable(sec_q.locked))
        else $error("master unlock not barred");

    a_tries_count: assert property (
        seq_unl_finish ##0 mismatch && !master_barred && sec_q.locked && sec_q.tries != 3'h0
        |=> sec_q.tries == $past(sec_q.tries) - 3'h1)
        else $error("tries not decremented");

    a_zero_refuses: assert property (
        (state_q == S_DECODE) && is_unl && (sec_q.tries == 3'h0) && !hw_reset_i
        |=> error_q[ERR_COMMAND_REJECTED_FLAG] ##1 (state_q == S_IDLE))
        else $error("unlock not refused at zero");

    a_unlocked_keep: assert property (
        !sec_q.locked && !hw_reset_i |=> $stable(sec_q.tries))
        else $error("tries moved while unlocked");

    a_tries_range: assert property (
        sec_q.tries <= TRIES_INIT)
        else $error("tries out of range");

    a_frozen_hold: assert property (
        sec_q.frozen && !hw_reset_i |=> sec_q.frozen)
        else $error("frozen left early");

endmodule : dpsu_core

// ---- core/dpsu_pkg.sv ----
// Shared constants and types for the drive password set and unlock logic
package dpsu_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_ERROR = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_DEVHEAD = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_SECSTATE = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h18;

    // ----------------------------------------
    // Opcodes and bit positions
    // ----------------------------------------
    localparam logic [7:0] OPC_SET_PWD = 8'hF1;
    localparam logic [7:0] OPC_UNLOCK = 8'hF2;
    localparam logic [7:0] OPC_FREEZE = 8'hF5;
    localparam int STAT_BUSY = 7;
    localparam int STAT_READY = 6;
    localparam int STAT_FAULT = 5;
    localparam int STAT_DRQ = 3;
    localparam int STAT_ERR = 0;
    localparam int ERR_COMMAND_REJECTED_FLAG = 2;
    localparam int DEV_BIT = 4;
    localparam int CW_ID_BIT = 0;
    localparam int CW_LVL_BIT = 8;
    localparam int CTRL_SUPPORT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // ----------------------------------------
    // Parameter sector layout
    // ----------------------------------------
    localparam int WORD_W = 16;
    localparam int PWD_WORDS = 16;
    localparam logic [7:0] WORD_CTRL = 8'h00;
    localparam logic [7:0] WORD_PWD_FIRST = 8'h01;
    localparam logic [7:0] WORD_PWD_LAST = 8'h10;
    localparam logic [7:0] WORD_REV = 8'h11;
    localparam logic [7:0] WORD_LAST = 8'hFF;
    localparam logic [15:0] REV_DEFAULT = 16'hFFFE;
    localparam logic [15:0] REV_RESERVED = 16'hFFFF;
    localparam logic [2:0] TRIES_INIT = 3'h5;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_DECODE = 4'b0010,
        S_XFER = 4'b0100,
        S_FINISH = 4'b1000
    } dpsu_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } dpsu_apb_s;

    typedef struct packed {
        logic [15:0] rev;
        logic [2:0] tries;
        logic level_max;
        logic armed;
        logic locked;
        logic frozen;
    } dpsu_sec_s;

endpackage : dpsu_pkg

// ---- core/dpsu_pwd_bank.sv ----
// Stored User and Master passwords with a running word compare
`timescale 1ns/1ns
module dpsu_pwd_bank
    import dpsu_pkg::*;
#(
    parameter int WORDS = PWD_WORDS,
    parameter int W = WORD_W
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Word stream
    input wire logic clr_i,
    input wire logic we_i,
    input wire logic cmp_i,
    input wire logic sel_master_i,
    input wire logic [$clog2(WORDS)-1:0] idx_i,
    input wire logic [W-1:0] word_i,
    // Result
    output logic mismatch_o
);

    logic [W-1:0] user_q [WORDS];
    logic [W-1:0] master_q [WORDS];
    logic [W-1:0] ref_word;

    assign ref_word = sel_master_i ? master_q[idx_i] : user_q[idx_i];

    // Blank passwords after power-on; nothing here is kept across power loss
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < WORDS; i++) begin
                user_q[i] <= '0;
                master_q[i] <= '0;
            end
        end else if (we_i) begin
            if (sel_master_i) begin
                master_q[idx_i] <= word_i;
            end else begin
                user_q[idx_i] <= word_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mismatch_o <= 1'b0;
        end else if (clr_i) begin
            mismatch_o <= 1'b0;
        end else if (cmp_i && (ref_word != word_i)) begin
            mismatch_o <= 1'b1;
        end
    end

endmodule : dpsu_pwd_bank

// ---- bench/dpsu_host_model.sv ----
// Host adapter model issuing commands over APB
`timescale 1ns/1ns
module dpsu_host_model
    import dpsu_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // APB master
    output dpsu_apb_s apb_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i
);
    initial begin
        apb_o = '0;
    end
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Released address and write data lines are inverted so stale values cannot pass as live ones
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        apb_o.psel <= 1'b1;
        apb_o.penable <= 1'b0;
        apb_o.pwrite <= w;
        apb_o.paddr <= a;
        apb_o.pwdata <= d;
        @(posedge sys_clk_i);
        apb_o.penable <= 1'b1;
        do begin
            @(posedge sys_clk_i);
        end while (pready_i !== 1'b1);
        q = prdata_i;
        apb_o.psel <= 1'b0;
        apb_o.penable <= 1'b0;
        apb_o.paddr <= ~a;
        apb_o.pwdata <= ~d;
        @(posedge sys_clk_i);
    endtask : xfer
    task automatic poll(output logic [31:0] s);
        int i;
        for (i = 0; i < 20; i++) begin
            xfer(1'b0, ADDR_STATUS, 32'h0, s);
            if (s[STAT_BUSY] === 1'b0) break;
        end
    endtask : poll
    task automatic cmd(input logic [7:0] op, input logic [15:0] cw, input logic [15:0] pw,
                       input logic [15:0] rv, input logic [15:0] x);
        logic [31:0] s;
        logic [31:0] t;
        logic [15:0] wd;
        int i;
        poll(s);
        xfer(1'b1, ADDR_CMD, {24'h0, op}, t);
        poll(s);
        for (i = 0; i < 256 && s[STAT_DRQ] === 1'b1; i++) begin
            wd = (i == 0) ? cw : (i == 17) ? rv : (i > 0 && i < 17) ? pw + 16'(i) : 16'h0;
            xfer(1'b1, ADDR_DATA, {16'h0, wd ^ ((i == 16) ? x : 16'h0)}, t);
        end
        poll(s);
    endtask : cmd
endmodule : dpsu_host_model

// ---- bench/tb_drive_password_set_unlock_logic.sv ----
// Self-checking bench for the password set and unlock engine
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_drive_password_set_unlock_logic
    import dpsu_pkg::*;
;
    logic sys_clk_i;
    logic rstn_i;
    logic hw_reset_i;
    dpsu_apb_s apb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic locked;
    logic frozen;
    logic [31:0] q;
    int n_fail;
    int compares;
    logic slverr_q;
    localparam logic [15:0] PA = 16'h1100;
    localparam logic [15:0] PM = 16'h2200;
    dpsu_core dpsu_core_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hw_reset_i(hw_reset_i), .apb_i(apb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .locked_o(locked), .frozen_o(frozen));
    dpsu_host_model dpsu_host_model_i (.sys_clk_i(sys_clk_i), .apb_o(apb), .prdata_i(prdata), .pready_i(pready));
    // Error response is only meaningful in the access phase
    always @(posedge sys_clk_i) begin
        if (apb.psel && apb.penable) begin
            slverr_q <= pslverr;
        end
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic rd(input logic [7:0] a);
        dpsu_host_model_i.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        dpsu_host_model_i.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic c(input logic [7:0] op, input logic [15:0] cw, input logic [15:0] pw,
                     input logic [15:0] x, input logic e);
        dpsu_host_model_i.cmd(op, cw, pw, 16'h1234, x);
        rd(ADDR_STATUS);
        `CHK(q[7:0], {7'h20, e})
        rd(ADDR_ERROR);
        `CHK(q[7:0], {5'h0, e, 2'h0})
    endtask : c
    task automatic hwr();
        hw_reset_i <= 1'b1;
        @(posedge sys_clk_i);
        hw_reset_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask : hwr
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_set();
        rd(ADDR_SECSTATE);
        `CHK(q[22:0], {16'hFFFE, 3'h5, 4'h0})
        `CHK(slverr_q, 1'b0)
        rd(8'h1C);
        `CHK(q, 32'h0)
        `CHK(slverr_q, 1'b1)
        wr(ADDR_DEVHEAD, 32'h10);
        c(OPC_SET_PWD, 16'h0000, PA, 16'h0, 1'b0);
        c(OPC_SET_PWD, 16'h0001, PM, 16'h0, 1'b0);
        rd(ADDR_SECSTATE);
        `CHK(q[22:0], {16'h1234, 3'h5, 4'h4})
        rd(ADDR_DEVHEAD);
        `CHK(q[7:0], 8'h10)
        hwr();
        `CHK(locked, 1'b1)
        c(OPC_SET_PWD, 16'h0000, PA, 16'h0, 1'b1);
    endtask : t_set
    task automatic t_high();
        c(OPC_UNLOCK, 16'h0000, PA, 16'h0001, 1'b1);
        c(OPC_UNLOCK, 16'h0001, PM, 16'h0, 1'b0);
        `CHK(locked, 1'b0)
        c(OPC_UNLOCK, 16'h0000, PA, 16'h0100, 1'b1);
        rd(ADDR_SECSTATE);
        `CHK(q[6:4], 3'h4)
    endtask : t_high
    task automatic t_max();
        int i;
        c(OPC_SET_PWD, 16'h0100, PA, 16'h0, 1'b0);
        hwr();
        c(OPC_UNLOCK, 16'h0001, PM, 16'h0, 1'b1);
        for (i = 0; i < 6; i++) begin
            c(OPC_UNLOCK, 16'h0000, PA, 16'h8000, 1'b1);
            rd(ADDR_SECSTATE);
            `CHK(q[6:4], 3'((i < 5) ? 4 - i : 0))
        end
        c(OPC_UNLOCK, 16'h0000, PA, 16'h0, 1'b1);
        `CHK(locked, 1'b1)
        hwr();
        c(OPC_UNLOCK, 16'h0000, PA, 16'h0, 1'b0);
        `CHK(locked, 1'b0)
    endtask : t_max
    task automatic t_frz();
        c(OPC_FREEZE, 16'h0, 16'h0, 16'h0, 1'b0);
        c(OPC_SET_PWD, 16'h0000, PA, 16'h0, 1'b1);
        c(OPC_UNLOCK, 16'h0000, PA, 16'h0, 1'b1);
        `CHK(frozen, 1'b1)
        hwr();
        `CHK(frozen, 1'b0)
        wr(ADDR_CTRL, 32'h0);
        c(OPC_UNLOCK, 16'h0000, PA, 16'h0, 1'b1);
        c(OPC_SET_PWD, 16'h0000, PA, 16'h0, 1'b1);
        wr(ADDR_CTRL, 32'h1);
        c(8'h00, 16'h0, 16'h0, 16'h0, 1'b1);
        c(OPC_FREEZE, 16'h0, 16'h0, 16'h0, 1'b1);
        `CHK(frozen, 1'b0)
    endtask : t_frz
    task automatic stop_test();
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // Worst case is about thirteen full sectors; this leaves wide margin
    initial begin
        #2000000;
        n_fail++;
        stop_test();
    end
    initial begin
        rstn_i = 1'b0;
        hw_reset_i = 1'b0;
        n_fail = 0;
        compares = 0;
        repeat (16) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        @(posedge sys_clk_i);
        t_set();
        t_high();
        t_max();
        t_frz();
        stop_test();
    end
endmodule : tb_drive_password_set_unlock_logic
